// ---- logic/cmb_pkg.sv ----
package cmb_pkg;

  // command bytes of the bank
  localparam logic [7:0] CMD_ALARM2_MASK      = 8'h0d;
  localparam logic [7:0] CMD_ALARM3_MASK      = 8'h0e;
  localparam logic [7:0] CMD_LOCAL_LIMIT      = 8'h40;
  localparam logic [7:0] CMD_R1_ALARM1_LIMIT  = 8'h41;
  localparam logic [7:0] CMD_R2_ALARM1_LIMIT  = 8'h42;
  localparam logic [7:0] CMD_R3_SHARED_LIMIT  = 8'h43;
  localparam logic [7:0] CMD_R4_SHARED_LIMIT  = 8'h44;
  localparam logic [7:0] CMD_R1_ALARM23_LIMIT = 8'h49;
  localparam logic [7:0] CMD_R2_ALARM23_LIMIT = 8'h4a;
  localparam logic [7:0] CMD_HYSTERESIS       = 8'h5a;

  // field widths
  localparam int unsigned MASK_W  = 5;
  localparam int unsigned LLIM_W  = 7;
  localparam int unsigned RLIM_W  = 8;
  localparam int unsigned HYST_W  = 5;
  localparam int unsigned CMP_W   = 10;

  // channel bit positions inside the mask and status vectors
  localparam int unsigned CH_LOCAL = 0;
  localparam int unsigned CH_R1    = 1;
  localparam int unsigned CH_R2    = 2;
  localparam int unsigned CH_R3    = 3;
  localparam int unsigned CH_R4    = 4;

  // power-on values
  localparam logic [MASK_W-1:0] RST_ALARM2_MASK  = 5'h00;
  localparam logic [MASK_W-1:0] RST_ALARM3_MASK  = 5'h07;
  localparam logic [LLIM_W-1:0] RST_LOCAL_LIMIT  = 7'h55;
  localparam logic [RLIM_W-1:0] RST_ALARM1_LIMIT = 8'h6e;
  localparam logic [RLIM_W-1:0] RST_SHARED_LIMIT = 8'h55;
  localparam logic [RLIM_W-1:0] RST_ALARM23_LIMIT = 8'h55;
  localparam logic [HYST_W-1:0] RST_HYSTERESIS   = 5'h0a;
  localparam logic [7:0]        RDATA_ZERO       = 8'h00;

  // one conversion result, whole degrees
  typedef struct packed {
    logic signed [7:0] local_t;
    logic [7:0]        remote1_t;
    logic [7:0]        remote2_t;
    logic [7:0]        remote3_t;
    logic [7:0]        remote4_t;
  } cmb_temps_t;

  // host access toward the bank
  typedef struct packed {
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } cmb_reg_req_t;

  // per-channel error status, one set per limit group
  typedef struct packed {
    logic [MASK_W-1:0] alarm1;
    logic [MASK_W-1:0] alarm23;
  } cmb_status_t;

endpackage : cmb_pkg

// ---- logic/cmb_limit_cmp.sv ----
`timescale 1ns/1ps
module cmb_limit_cmp #(
  parameter int unsigned W  = 10,
  parameter int unsigned LW = 8,
  parameter int unsigned HW = 5
) (
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  // comparison inputs
  input  wire logic                sample_i,
  input  wire logic signed [W-1:0] reading_i,
  input  wire logic [LW-1:0]       limit_i,
  input  wire logic [HW-1:0]       hyst_i,
  // error status
  output logic                     hit_o
);

  logic                hit_q;
  logic                hit_d;
  logic signed [W-1:0] lim_s;
  logic signed [W-1:0] low_s;

  // widened and signed so that limit minus hysteresis may go below zero
  assign lim_s = $signed({{(W-LW){1'b0}}, limit_i});
  assign low_s = lim_s - $signed({{(W-HW){1'b0}}, hyst_i});

  always_comb begin
    hit_d = hit_q;
    if (sample_i) begin
      if (reading_i >= lim_s) begin
        hit_d = 1'b1;                   // [RULE10]
      end else if (reading_i < low_s) begin
        hit_d = 1'b0;                   // [RULE10] [RULE11]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  assign hit_o = hit_q;

endmodule : cmb_limit_cmp

// ---- logic/cmb_bank.sv ----
// What this block does
// [RULE1] alarm-2 mask: bit 1 blocks channel error from crit_out_2; order r4,r3,r2,r1,local
// [RULE2] alarm-3 mask gates channel errors onto crit_out_3 with same bit order
// [RULE3] mask bits 7 to 5 always read zero
// [RULE4] local error judged against local limit, whole degrees 0 to 127
// [RULE5] local limit bit 7 reads zero and ignores writes
// [RULE6] remote limits are full 8-bit unsigned, all bits writable
// [RULE7] remote 1 and 2 alarm-1 events use their own alarm-1 limits
// [RULE8] remote 1 and 2 alarm-2/3 events use a separate limit pair
// [RULE9] remote 3 and 4 each use one limit shared by all outputs
// [RULE10] status sets at or above limit, clears below limit minus hysteresis
// [RULE11] one common hysteresis value lowers every limit for falling temperature
// [RULE12] an alarm asserts while any unmasked channel status is set
// [RULE13] reset loads every mask and limit default before any comparison; the alarm-1 mask comes in on alarm1_mask_i and is not reset here
`timescale 1ns/1ps
module cmb_bank (
  // clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_n_i,
  // host register access by command byte
  input  wire cmb_pkg::cmb_reg_req_t           reg_req_i,
  output logic [7:0]                           reg_rdata_o,
  // conversion results
  input  wire logic                            temps_valid_i,
  input  wire cmb_pkg::cmb_temps_t             temps_i,
  // first output mask lives outside this bank
  input  wire logic [cmb_pkg::MASK_W-1:0]      alarm1_mask_i,
  // alarm pins, active low
  output logic                                 crit_out_1_n_o,
  output logic                                 crit_out_2_n_o,
  output logic                                 crit_out_3_n_o,
  // error status toward the status registers
  output cmb_pkg::cmb_status_t                 status_o
);

  localparam int unsigned MW = cmb_pkg::MASK_W;
  localparam int unsigned LW = cmb_pkg::LLIM_W;
  localparam int unsigned RW = cmb_pkg::RLIM_W;
  localparam int unsigned HW = cmb_pkg::HYST_W;
  localparam int unsigned CW = cmb_pkg::CMP_W;

  // register state
  logic [MW-1:0] mask2_q;
  logic [MW-1:0] mask2_d;
  logic [MW-1:0] mask3_q;
  logic [MW-1:0] mask3_d;
  logic [LW-1:0] loc_lim_q;
  logic [LW-1:0] loc_lim_d;
  logic [RW-1:0] r1a1_lim_q;
  logic [RW-1:0] r1a1_lim_d;
  logic [RW-1:0] r2a1_lim_q;
  logic [RW-1:0] r2a1_lim_d;
  logic [RW-1:0] r3_lim_q;
  logic [RW-1:0] r3_lim_d;
  logic [RW-1:0] r4_lim_q;
  logic [RW-1:0] r4_lim_d;
  logic [RW-1:0] r1a23_lim_q;
  logic [RW-1:0] r1a23_lim_d;
  logic [RW-1:0] r2a23_lim_q;
  logic [RW-1:0] r2a23_lim_d;
  logic [HW-1:0] hyst_q;
  logic [HW-1:0] hyst_d;
  logic [7:0]    rdata_q;
  logic [7:0]    rdata_d;

  // alarm state
  logic          crit1_n_q;
  logic          crit1_n_d;
  logic          crit2_n_q;
  logic          crit2_n_d;
  logic          crit3_n_q;
  logic          crit3_n_d;

  // comparison results
  logic          hit_loc;
  logic          hit_r1a1;
  logic          hit_r2a1;
  logic          hit_r1a23;
  logic          hit_r2a23;
  logic          hit_r3;
  logic          hit_r4;
  logic [MW-1:0] err_a1;
  logic [MW-1:0] err_a23;

  // readings widened to one signed compare width
  logic signed [CW-1:0] rd_loc;
  logic signed [CW-1:0] rd_r1;
  logic signed [CW-1:0] rd_r2;
  logic signed [CW-1:0] rd_r3;
  logic signed [CW-1:0] rd_r4;

  assign rd_loc = CW'(temps_i.local_t);
  assign rd_r1  = $signed({{(CW-8){1'b0}}, temps_i.remote1_t});
  assign rd_r2  = $signed({{(CW-8){1'b0}}, temps_i.remote2_t});
  assign rd_r3  = $signed({{(CW-8){1'b0}}, temps_i.remote3_t});
  assign rd_r4  = $signed({{(CW-8){1'b0}}, temps_i.remote4_t});

  // register writes
  always_comb begin
    mask2_d     = mask2_q;
    mask3_d     = mask3_q;
    loc_lim_d   = loc_lim_q;
    r1a1_lim_d  = r1a1_lim_q;
    r2a1_lim_d  = r2a1_lim_q;
    r3_lim_d    = r3_lim_q;
    r4_lim_d    = r4_lim_q;
    r1a23_lim_d = r1a23_lim_q;
    r2a23_lim_d = r2a23_lim_q;
    hyst_d      = hyst_q;
    if (reg_req_i.wr) begin
      unique case (reg_req_i.cmd)
        cmb_pkg::CMD_ALARM2_MASK: begin
          mask2_d = reg_req_i.wdata[MW-1:0];      // [RULE1] [RULE3]
        end
        cmb_pkg::CMD_ALARM3_MASK: begin
          mask3_d = reg_req_i.wdata[MW-1:0];      // [RULE2] [RULE3]
        end
        cmb_pkg::CMD_LOCAL_LIMIT: begin
          loc_lim_d = reg_req_i.wdata[LW-1:0];    // [RULE5]
        end
        cmb_pkg::CMD_R1_ALARM1_LIMIT: begin
          r1a1_lim_d = reg_req_i.wdata;           // [RULE6]
        end
        cmb_pkg::CMD_R2_ALARM1_LIMIT: begin
          r2a1_lim_d = reg_req_i.wdata;           // [RULE6]
        end
        cmb_pkg::CMD_R3_SHARED_LIMIT: begin
          r3_lim_d = reg_req_i.wdata;             // [RULE6]
        end
        cmb_pkg::CMD_R4_SHARED_LIMIT: begin
          r4_lim_d = reg_req_i.wdata;             // [RULE6]
        end
        cmb_pkg::CMD_R1_ALARM23_LIMIT: begin
          r1a23_lim_d = reg_req_i.wdata;          // [RULE6]
        end
        cmb_pkg::CMD_R2_ALARM23_LIMIT: begin
          r2a23_lim_d = reg_req_i.wdata;          // [RULE6]
        end
        cmb_pkg::CMD_HYSTERESIS: begin
          hyst_d = reg_req_i.wdata[HW-1:0];       // [RULE11]
        end
        default: begin
          // other command bytes belong to other banks
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask2_q     <= cmb_pkg::RST_ALARM2_MASK;    // [RULE13]
      mask3_q     <= cmb_pkg::RST_ALARM3_MASK;
      loc_lim_q   <= cmb_pkg::RST_LOCAL_LIMIT;
      r1a1_lim_q  <= cmb_pkg::RST_ALARM1_LIMIT;
      r2a1_lim_q  <= cmb_pkg::RST_ALARM1_LIMIT;
      r3_lim_q    <= cmb_pkg::RST_SHARED_LIMIT;
      r4_lim_q    <= cmb_pkg::RST_SHARED_LIMIT;
      r1a23_lim_q <= cmb_pkg::RST_ALARM23_LIMIT;
      r2a23_lim_q <= cmb_pkg::RST_ALARM23_LIMIT;
      hyst_q      <= cmb_pkg::RST_HYSTERESIS;
    end else begin
      mask2_q     <= mask2_d;
      mask3_q     <= mask3_d;
      loc_lim_q   <= loc_lim_d;
      r1a1_lim_q  <= r1a1_lim_d;
      r2a1_lim_q  <= r2a1_lim_d;
      r3_lim_q    <= r3_lim_d;
      r4_lim_q    <= r4_lim_d;
      r1a23_lim_q <= r1a23_lim_d;
      r2a23_lim_q <= r2a23_lim_d;
      hyst_q      <= hyst_d;
    end
  end

  // readback, registered; unmapped commands read zero
  always_comb begin
    rdata_d = cmb_pkg::RDATA_ZERO;
    unique case (reg_req_i.cmd)
      cmb_pkg::CMD_ALARM2_MASK: begin
        rdata_d = {{(8-MW){1'b0}}, mask2_q};      // [RULE3]
      end
      cmb_pkg::CMD_ALARM3_MASK: begin
        rdata_d = {{(8-MW){1'b0}}, mask3_q};      // [RULE3]
      end
      cmb_pkg::CMD_LOCAL_LIMIT: begin
        rdata_d = {{(8-LW){1'b0}}, loc_lim_q};    // [RULE5]
      end
      cmb_pkg::CMD_R1_ALARM1_LIMIT: begin
        rdata_d = r1a1_lim_q;
      end
      cmb_pkg::CMD_R2_ALARM1_LIMIT: begin
        rdata_d = r2a1_lim_q;
      end
      cmb_pkg::CMD_R3_SHARED_LIMIT: begin
        rdata_d = r3_lim_q;
      end
      cmb_pkg::CMD_R4_SHARED_LIMIT: begin
        rdata_d = r4_lim_q;
      end
      cmb_pkg::CMD_R1_ALARM23_LIMIT: begin
        rdata_d = r1a23_lim_q;
      end
      cmb_pkg::CMD_R2_ALARM23_LIMIT: begin
        rdata_d = r2a23_lim_q;
      end
      cmb_pkg::CMD_HYSTERESIS: begin
        rdata_d = {{(8-HW){1'b0}}, hyst_q};
      end
      default: begin
        rdata_d = cmb_pkg::RDATA_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= cmb_pkg::RDATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // one comparator per limit; remote 1 and 2 carry two each
  cmb_limit_cmp #(.W(CW), .LW(LW), .HW(HW)) u_cmp_loc (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_loc),
    .limit_i    (loc_lim_q),                      // [RULE4]
    .hyst_i     (hyst_q),
    .hit_o      (hit_loc)
  );

  cmb_limit_cmp #(.W(CW), .LW(RW), .HW(HW)) u_cmp_r1a1 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_r1),
    .limit_i    (r1a1_lim_q),                     // [RULE7]
    .hyst_i     (hyst_q),
    .hit_o      (hit_r1a1)
  );

  cmb_limit_cmp #(.W(CW), .LW(RW), .HW(HW)) u_cmp_r2a1 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_r2),
    .limit_i    (r2a1_lim_q),                     // [RULE7]
    .hyst_i     (hyst_q),
    .hit_o      (hit_r2a1)
  );

  cmb_limit_cmp #(.W(CW), .LW(RW), .HW(HW)) u_cmp_r1a23 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_r1),
    .limit_i    (r1a23_lim_q),                    // [RULE8]
    .hyst_i     (hyst_q),
    .hit_o      (hit_r1a23)
  );

  cmb_limit_cmp #(.W(CW), .LW(RW), .HW(HW)) u_cmp_r2a23 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_r2),
    .limit_i    (r2a23_lim_q),                    // [RULE8]
    .hyst_i     (hyst_q),
    .hit_o      (hit_r2a23)
  );

  cmb_limit_cmp #(.W(CW), .LW(RW), .HW(HW)) u_cmp_r3 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_r3),
    .limit_i    (r3_lim_q),                       // [RULE9]
    .hyst_i     (hyst_q),
    .hit_o      (hit_r3)
  );

  cmb_limit_cmp #(.W(CW), .LW(RW), .HW(HW)) u_cmp_r4 (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .sample_i   (temps_valid_i),
    .reading_i  (rd_r4),
    .limit_i    (r4_lim_q),                       // [RULE9]
    .hyst_i     (hyst_q),
    .hit_o      (hit_r4)
  );

  // channel error vectors in mask bit order
  always_comb begin
    err_a1                      = '0;
    err_a23                     = '0;
    err_a1[cmb_pkg::CH_LOCAL]   = hit_loc;
    err_a1[cmb_pkg::CH_R1]      = hit_r1a1;       // [RULE7]
    err_a1[cmb_pkg::CH_R2]      = hit_r2a1;
    err_a1[cmb_pkg::CH_R3]      = hit_r3;         // [RULE9]
    err_a1[cmb_pkg::CH_R4]      = hit_r4;
    err_a23[cmb_pkg::CH_LOCAL]  = hit_loc;
    err_a23[cmb_pkg::CH_R1]     = hit_r1a23;      // [RULE8]
    err_a23[cmb_pkg::CH_R2]     = hit_r2a23;
    err_a23[cmb_pkg::CH_R3]     = hit_r3;         // [RULE9]
    err_a23[cmb_pkg::CH_R4]     = hit_r4;
  end

  // pins are active low; registered to keep them glitch free
  always_comb begin
    crit1_n_d = ~|(err_a1 & ~alarm1_mask_i);      // [RULE12]
    crit2_n_d = ~|(err_a23 & ~mask2_q);           // [RULE1] [RULE12]
    crit3_n_d = ~|(err_a23 & ~mask3_q);           // [RULE2] [RULE12]
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crit1_n_q <= 1'b1;
      crit2_n_q <= 1'b1;
      crit3_n_q <= 1'b1;
    end else begin
      crit1_n_q <= crit1_n_d;
      crit2_n_q <= crit2_n_d;
      crit3_n_q <= crit3_n_d;
    end
  end

  assign crit_out_1_n_o   = crit1_n_q;
  assign crit_out_2_n_o   = crit2_n_q;
  assign crit_out_3_n_o   = crit3_n_q;
  assign reg_rdata_o      = rdata_q;
  assign status_o.alarm1  = err_a1;
  assign status_o.alarm23 = err_a23;

endmodule : cmb_bank

// ---- tb/cmb_bank_monitor.sv ----
`timescale 1ns/1ps
module cmb_bank_monitor (
  // clock and reset
  input wire logic                       core_clk_i,
  input wire logic                       rst_n_i,
  // register access
  input wire cmb_pkg::cmb_reg_req_t      reg_req_i,
  input wire logic [7:0]                 reg_rdata_o,
  // conversions
  input wire logic                       temps_valid_i,
  input wire cmb_pkg::cmb_temps_t        temps_i,
  input wire logic [cmb_pkg::MASK_W-1:0] alarm1_mask_i,
  // alarms and status
  input wire logic                       crit_out_1_n_o,
  input wire logic                       crit_out_2_n_o,
  input wire logic                       crit_out_3_n_o,
  input wire cmb_pkg::cmb_status_t       status_o
);
  logic [4:0] m2_q;
  logic [4:0] m3_q;
  logic       mapped;
  logic       remote;
  assign mapped = reg_req_i.cmd inside {8'h0d, 8'h0e, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h49, 8'h4a, 8'h5a};
  assign remote = reg_req_i.cmd inside {8'h41, 8'h42, 8'h43, 8'h44, 8'h49, 8'h4a};
  // shadow masks, so pin gating can be judged from the ports alone
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m2_q <= cmb_pkg::RST_ALARM2_MASK;
      m3_q <= cmb_pkg::RST_ALARM3_MASK;
    end else if (reg_req_i.wr) begin
      if (reg_req_i.cmd == cmb_pkg::CMD_ALARM2_MASK) m2_q <= reg_req_i.wdata[4:0];
      if (reg_req_i.cmd == cmb_pkg::CMD_ALARM3_MASK) m3_q <= reg_req_i.wdata[4:0];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // mask latency is left open, so only judge once the mask has been steady
  pin2_gate_a: assert property (($past(m2_q) == m2_q && $past(m2_q, 2) == m2_q) |->
    crit_out_2_n_o == !(|($past(status_o.alarm23) & ~m2_q))) else $error("alarm 2 pin wrong");
  pin3_gate_a: assert property (($past(m3_q) == m3_q && $past(m3_q, 2) == m3_q) |->
    crit_out_3_n_o == !(|($past(status_o.alarm23) & ~m3_q))) else $error("alarm 3 pin wrong");
  pin1_gate_a: assert property (($stable(alarm1_mask_i) && $past(alarm1_mask_i, 2) == alarm1_mask_i) |->
    crit_out_1_n_o == !(|($past(status_o.alarm1) & ~alarm1_mask_i))) else $error("alarm 1 pin wrong");
  mask_rsv_a: assert property ($past(reg_req_i.cmd) inside {8'h0d, 8'h0e} |-> reg_rdata_o[7:5] == 3'h0)
    else $error("mask reserved bits set");
  loc_bit7_a: assert property ($past(reg_req_i.cmd) == 8'h40 |-> !reg_rdata_o[7])
    else $error("local limit bit 7 set");
  unmapped_zero_a: assert property (!$past(mapped) |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  rlim_back_a: assert property ((reg_req_i.wr && remote) ##1 (!reg_req_i.wr && $stable(reg_req_i.cmd)) |=>
    reg_rdata_o == $past(reg_req_i.wdata, 2)) else $error("remote limit readback wrong");
  stat_hold_a: assert property (!temps_valid_i |=> $stable(status_o)) else $error("status moved without sample");
  r3_hot_a: assert property (temps_valid_i && temps_i.remote3_t == 8'hff |=>
    status_o.alarm1[cmb_pkg::CH_R3] && status_o.alarm23[cmb_pkg::CH_R3]) else $error("remote 3 not set");
  loc_max_a: assert property (temps_valid_i && temps_i.local_t == 8'sd127 |=>
    status_o.alarm1[cmb_pkg::CH_LOCAL] && status_o.alarm23[cmb_pkg::CH_LOCAL]) else $error("local not set");
  rst_idle_a: assert property (disable iff (1'b0) !rst_n_i |->
    crit_out_1_n_o && crit_out_2_n_o && crit_out_3_n_o && status_o == '0) else $error("reset state wrong");
  cover property (temps_valid_i && temps_i.remote3_t == 8'hff);
  cover property (!crit_out_3_n_o);
  cover property ($fell(crit_out_1_n_o));
endmodule : cmb_bank_monitor

bind cmb_bank cmb_bank_monitor u_mon (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
  .reg_rdata_o(reg_rdata_o), .temps_valid_i(temps_valid_i), .temps_i(temps_i), .alarm1_mask_i(alarm1_mask_i),
  .crit_out_1_n_o(crit_out_1_n_o), .crit_out_2_n_o(crit_out_2_n_o), .crit_out_3_n_o(crit_out_3_n_o),
  .status_o(status_o));

// ---- tb/cmb_host_model.sv ----
`timescale 1ns/1ps
module cmb_host_model (
  // clock
  input  wire logic                 core_clk_i,
  // register port
  input  wire logic [7:0]           reg_rdata_i,
  output cmb_pkg::cmb_reg_req_t     reg_req_o
);
  initial reg_req_o = '0;
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_req_o <= '{wr: 1'b1, cmd: c, wdata: d};
    @(posedge core_clk_i);
    reg_req_o.wr <= 1'b0;
    // released data must not keep showing the written byte
    reg_req_o.wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_req_o.cmd <= c;
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    #1;
    d = reg_rdata_i;
  endtask : rd
endmodule : cmb_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] rst;
    logic [7:0] wd;
    logic [7:0] rb;
  } cmb_row_t;
  localparam cmb_row_t ROWS [11] = '{
    '{8'h0d, 8'h00, 8'hff, 8'h1f}, '{8'h0e, 8'h07, 8'he5, 8'h05}, '{8'h40, 8'h55, 8'hff, 8'h7f},
    '{8'h41, 8'h6e, 8'ha5, 8'ha5}, '{8'h42, 8'h6e, 8'h5a, 8'h5a}, '{8'h43, 8'h55, 8'hc3, 8'hc3},
    '{8'h44, 8'h55, 8'h3c, 8'h3c}, '{8'h49, 8'h55, 8'h81, 8'h81}, '{8'h4a, 8'h55, 8'h7e, 8'h7e},
    '{8'h5a, 8'h0a, 8'hff, 8'h1f}, '{8'h50, 8'h00, 8'hff, 8'h00}};
  logic                  core_clk_i = 1'b0;
  logic                  rst_n_i    = 1'b1;
  cmb_pkg::cmb_reg_req_t reg_req;
  logic [7:0]            rdata;
  logic                  tvalid     = 1'b0;
  cmb_pkg::cmb_temps_t   temps      = '0;
  logic [4:0]            a1_mask    = 5'h00;
  logic                  c1_n;
  logic                  c2_n;
  logic                  c3_n;
  cmb_pkg::cmb_status_t  status;
  logic [7:0]            rv;
  int                    n_errors   = 0;
  int                    n_checks   = 0;
  always #20 core_clk_i = ~core_clk_i;
  cmb_host_model u_host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_req_o(reg_req));
  cmb_bank u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
    .temps_valid_i(tvalid), .temps_i(temps), .alarm1_mask_i(a1_mask), .crit_out_1_n_o(c1_n),
    .crit_out_2_n_o(c2_n), .crit_out_3_n_o(c3_n), .status_o(status));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // pins are {crit3, crit2, crit1}, active low
  task automatic conv(input logic [39:0] t, input logic [9:0] es, input logic [2:0] ep);
    @(posedge core_clk_i);
    tvalid <= 1'b1;
    temps <= t;
    @(posedge core_clk_i);
    tvalid <= 1'b0;
    temps <= ~t;
    @(posedge core_clk_i);
    #1;
    check(status, es);
    check({c3_n, c2_n, c1_n}, ep);
  endtask : conv
  task automatic settle(input logic [2:0] ep);
    repeat (3) @(posedge core_clk_i);
    #1;
    check({c3_n, c2_n, c1_n}, ep);
  endtask : settle
  initial begin
    // a real falling edge at time zero, else flops stay unknown until the first clock
    rst_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    foreach (ROWS[i]) begin
      u_host.rd(ROWS[i].cmd, rv);
      check(rv, ROWS[i].rst);
      u_host.wr(ROWS[i].cmd, ROWS[i].wd);
      u_host.rd(ROWS[i].cmd, rv);
      check(rv, ROWS[i].rb);
    end
    u_host.wr(8'h0d, 8'h00);
    u_host.wr(8'h0e, 8'h00);
    u_host.wr(8'h41, 8'h64);
    u_host.wr(8'h49, 8'h32);
    u_host.wr(8'h5a, 8'h05);
    conv(40'h00_4b_00_00_00, 10'h002, 3'b001);
    u_host.wr(8'h0d, 8'h02);
    settle(3'b011);
    conv(40'h00_30_00_00_00, 10'h002, 3'b011);
    conv(40'h00_2c_00_00_00, 10'h000, 3'b111);
    conv(40'h00_31_00_00_00, 10'h000, 3'b111);
    conv(40'h00_32_00_00_00, 10'h002, 3'b011);
    conv(40'h00_64_00_00_00, 10'h042, 3'b010);
    @(posedge core_clk_i);
    a1_mask <= 5'h02;
    settle(3'b011);
    conv(40'h7f_64_7e_ff_3c, 10'h3ff, 3'b000);
    conv(40'h7f_64_64_ff_3c, 10'h3fb, 3'b000);
    u_host.wr(8'h0e, 8'h1f);
    settle(3'b100);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    check({status, c3_n, c2_n, c1_n}, {10'h000, 3'b111});
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    u_host.rd(8'h41, rv);
    check(rv, 8'h6e);
    results();
  end
  // whole run is about 150 cycles
  initial begin
    #100us;
    n_errors++;
    results();
  end
endmodule : tb_top
